//--- src/adcsl_defines.vh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADCSL_DEFINES_VH
`define ADCSL_DEFINES_VH
// ==========================================================================
// register byte addresses (avalon address compared as is, not word aligned)
`define ADCSL_OFF_RES_LOW    8'h78
`define ADCSL_OFF_RES_HIGH   8'h79
`define ADCSL_OFF_CTRL_A     8'h7a
`define ADCSL_OFF_INPUT_SEL  8'h7c
`define ADCSL_OFF_IRQ_STAT   8'h80
`define ADCSL_OFF_IRQ_MASK   8'h84
// ==========================================================================
// control_status_register_a fields
`define ADCSL_CA_ENABLE      7
`define ADCSL_CA_START       6
`define ADCSL_CA_DONE        4
`define ADCSL_CA_IRQ_EN      3
// ==========================================================================
// input_select_register fields, reset values of both registers, temperature channel code
`define ADCSL_IS_REF         6
`define ADCSL_IS_LADJ        5
`define ADCSL_IS_WMASK       8'h6f
`define ADCSL_IS_RESET       8'h00
`define ADCSL_CA_RESET       8'h00
`define ADCSL_TEMP_CHANNEL   4'h8
// ==========================================================================
// interrupt status bits
`define ADCSL_EV_DONE        0
`define ADCSL_EV_SLEEP_CONV  1
// ==========================================================================
// sleep states from the sleep controller
`define ADCSL_SLP_ACTIVE     2'h0
`define ADCSL_SLP_IDLE       2'h1
`define ADCSL_SLP_NOISE_RED  2'h2
`define ADCSL_SLP_PWR_DOWN   2'h3
// ==========================================================================
// timing in converter clocks, prescaler of system clocks per converter clock
`define ADCSL_CONV_NORMAL    5'h0d
`define ADCSL_CONV_FIRST     5'h19
`define ADCSL_PRESC_DIV      8'h80
`endif

//--- src/adcsl_sar_core.v
// successive-approximation model of the converter: one result bit per step
`timescale 1ns/10ps
`default_nettype none
module adcsl_sar_core (
  // clock and reset
  input  wire       sys_clk,
  input  wire       resetn,
  // control
  input  wire       start,
  input  wire       step,
  input  wire [9:0] analog_code,
  // result
  output reg  [9:0] code_q,
  output reg        ready_q
);
  reg [3:0] bit_q;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      code_q  <= 10'h000;
      bit_q   <= 4'h0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b0;
      if (start) begin
        code_q <= 10'h000;
        bit_q  <= 4'h9;
      end else if (step && bit_q != 4'hf) begin
        // trial bit kept when the held sample is at or above it
        if (analog_code[bit_q])
          code_q[bit_q] <= 1'b1;
        if (bit_q == 4'h0)
          ready_q <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end
    end
  end
endmodule // adcsl_sar_core
`default_nettype wire

//--- src/adcsl_top.v
// converter control: registers, sleep-started conversion, result format, channel routing
`timescale 1ns/10ps
`default_nettype none
`include "adcsl_defines.vh"
// How it works
// RULE_01 - sleep in idle or noise reduction with converter idle and enabled starts conversion
// RULE_02 - done interrupt from a sleep conversion wakes the core
// RULE_03 - early wake by another interrupt lets the conversion finish and still interrupt
// RULE_04 - other sleep states leave the converter enable untouched
// RULE_05 - result is unsigned ten bits, vin times 1024 over vref
// RULE_06 - result registers hold the code once the done flag is set
// RULE_07 - channel code 1000 routes and enables the temperature sensor
// RULE_08 - software uses internal reference and single mode for temperature
// RULE_09 - input select register at 0x7c: reference, left adjust, channel
// RULE_10 - bits 7 and 4 of input select ignore writes and read zero
// RULE_11 - reference change during a conversion waits for completion
// RULE_12 - reference bit 0 selects internal 1.1v, 1 selects analog supply
// RULE_13 - completion writes result, sets done, clears start together
// RULE_14 - left adjust changes the presented result at once
// RULE_15 - conversion takes 13 converter clocks, first after enable 25
// RULE_16 - wake request rises with the done interrupt when enabled
module adcsl_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // avalon-mm slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // sleep controller and interrupt controller
  input  wire [1:0]  sleep_state,
  input  wire        cpu_halted,
  input  wire        irq_ack,
  output reg         wake_req_q,
  output reg         done_irq_q,
  output reg         irq_q,
  // analog side
  input  wire [9:0]  analog_code,
  output reg  [3:0]  channel_select_q,
  output reg         reference_select_q,
  output reg         temp_sensor_en_q,
  output reg         converting_q
);
  // ==========================================================================
  // registers
  reg  [7:0] input_select_q;
  reg        converter_enable_q;
  reg        start_conversion_q;
  reg        conversion_done_q;
  reg        done_interrupt_enable_q;
  reg        first_pending_q;
  reg  [9:0] result_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_mask_q;
  reg        sleep_conv_q;
  reg  [7:0] presc_q;
  reg  [4:0] conv_cnt_q;
  reg        ack_q;
  reg        halt_used_q;
  wire [9:0] sar_code;
  wire [1:0] ev_set;
  wire [1:0] irq_stat_d;

  function [7:0] present_byte;
    input [9:0] res;
    input       ladj;
    input       high;
    begin
      case ({ladj, high})
        2'b00:   present_byte = res[7:0];
        2'b01:   present_byte = {6'h00, res[9:8]};
        2'b10:   present_byte = {res[1:0], 6'h00};
        default: present_byte = res[9:2];
      endcase
    end
  endfunction

  // one address comparator shared by every register strobe
  function reg_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      reg_hit = addr == off;
    end
  endfunction

  // a request seen while waitrequest is still high
  wire acc      = (avs_read | avs_write) & avs_waitrequest;
  wire conv_tick = converting_q && presc_q == `ADCSL_PRESC_DIV - 8'h01;
  wire sleep_ok = sleep_state == `ADCSL_SLP_IDLE || sleep_state == `ADCSL_SLP_NOISE_RED;
  // converter idle, enabled, interrupt enabled (single mode is the only mode here);
  // one start per halt, so a finished sleep conversion cannot start another one
  // in the cycles before its wake request reaches the core
  wire sleep_start = sleep_ok && cpu_halted && converter_enable_q && !converting_q &&
                     !start_conversion_q && done_interrupt_enable_q && !sleep_conv_q &&
                     !halt_used_q; // [RULE_01]
  wire conv_end = converting_q && conv_tick && conv_cnt_q == 5'h01;
  wire [4:0] conv_len = (first_pending_q || !converter_enable_q) ?
                        `ADCSL_CONV_FIRST : `ADCSL_CONV_NORMAL; // [RULE_15]

  // ==========================================================================
  // bus slave: one wait state, then answer
  // readdata is loaded on the accept edge so it already stands when waitrequest
  // is sampled low; a held request reloads it harmlessly
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
      if (acc && !ack_q)
        avs_waitrequest <= 1'b0;
      if (avs_read) begin
        case (avs_address)
          `ADCSL_OFF_RES_LOW:   avs_readdata <= {24'h000000,
                                  present_byte(result_q, input_select_q[`ADCSL_IS_LADJ], 1'b0)}; // [RULE_14]
          `ADCSL_OFF_RES_HIGH:  avs_readdata <= {24'h000000,
                                  present_byte(result_q, input_select_q[`ADCSL_IS_LADJ], 1'b1)}; // [RULE_06]
          `ADCSL_OFF_CTRL_A:    avs_readdata <= {24'h000000, converter_enable_q, start_conversion_q,
                                  1'b0, conversion_done_q, done_interrupt_enable_q, 3'h0};
          `ADCSL_OFF_INPUT_SEL: avs_readdata <= {24'h000000, input_select_q}; // [RULE_10]
          `ADCSL_OFF_IRQ_STAT:  avs_readdata <= {30'h00000000, irq_stat_q};
          `ADCSL_OFF_IRQ_MASK:  avs_readdata <= {30'h00000000, irq_mask_q};
          default:              avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ack_q blocks a second accept in the cycle waitrequest is low
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= acc && !ack_q;
  end
  wire take = ack_q;
  wire wr_ctrl_t = take && avs_write && reg_hit(avs_address, `ADCSL_OFF_CTRL_A);
  wire wr_isel_t = take && avs_write && reg_hit(avs_address, `ADCSL_OFF_INPUT_SEL);
  wire wr_mask_t = take && avs_write && reg_hit(avs_address, `ADCSL_OFF_IRQ_MASK);
  wire rd_stat_t = take && avs_read && reg_hit(avs_address, `ADCSL_OFF_IRQ_STAT);
  wire sw_go     = wr_ctrl_t && avs_writedata[`ADCSL_CA_START] &&
                   avs_writedata[`ADCSL_CA_ENABLE] && !converting_q;
  wire start_now = (sw_go || sleep_start) && !converting_q;

  // ==========================================================================
  // control register and conversion sequencer
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      converter_enable_q      <= 1'b0;
      start_conversion_q      <= 1'b0;
      conversion_done_q       <= 1'b0;
      done_interrupt_enable_q <= 1'b0;
      first_pending_q         <= 1'b1;
      converting_q            <= 1'b0;
      presc_q                 <= 8'h00;
      conv_cnt_q              <= 5'h00;
      sleep_conv_q            <= 1'b0;
      result_q                <= 10'h000;
    end else begin
      // sleep state never touches the enable [RULE_04]
      if (wr_ctrl_t) begin
        converter_enable_q      <= avs_writedata[`ADCSL_CA_ENABLE];
        done_interrupt_enable_q <= avs_writedata[`ADCSL_CA_IRQ_EN];
        if (!avs_writedata[`ADCSL_CA_ENABLE])
          first_pending_q <= 1'b1;
      end
      presc_q <= (converting_q && !conv_tick) ? presc_q + 8'h01 : 8'h00;
      if (start_now) begin
        converting_q       <= 1'b1;
        start_conversion_q <= 1'b1;
        sleep_conv_q       <= sleep_start;
        conv_cnt_q         <= conv_len; // [RULE_15]
        first_pending_q    <= 1'b0;
      end else if (converting_q && wr_ctrl_t && !avs_writedata[`ADCSL_CA_ENABLE]) begin
        // disabling aborts the conversion, no result
        converting_q       <= 1'b0;
        start_conversion_q <= 1'b0;
        sleep_conv_q       <= 1'b0;
      end else if (conv_tick) begin
        conv_cnt_q <= conv_cnt_q - 5'h01;
        if (conv_cnt_q == 5'h01) begin
          // the conversion runs on even if the core woke early [RULE_03]
          converting_q       <= 1'b0;
          start_conversion_q <= 1'b0;       // [RULE_13]
          result_q           <= sar_code;   // [RULE_05]
          sleep_conv_q       <= 1'b0;
        end
      end
      // hardware set wins over write-one clear and vector acknowledge
      if (conv_tick && conv_cnt_q == 5'h01 && !start_now)
        conversion_done_q <= 1'b1;          // [RULE_13]
      else if ((wr_ctrl_t && avs_writedata[`ADCSL_CA_DONE]) || irq_ack)
        conversion_done_q <= 1'b0;
    end
  end

  // ==========================================================================
  // one sleep start per halt; cleared as soon as the core runs again
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      halt_used_q <= 1'b0;
    else if (!cpu_halted)
      halt_used_q <= 1'b0;
    else if (sleep_start)
      halt_used_q <= 1'b1; // [RULE_01]
  end

  // ==========================================================================
  // converter core
  // sar stepped in converter clocks eleven down to two, so bit zero is in
  // before the result is latched on the last converter clock
  adcsl_sar_core u_sar (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .start       (start_now),
    .step        (conv_tick && conv_cnt_q <= 5'h0b),
    .analog_code (analog_code),
    .code_q      (sar_code),
    .ready_q     ()
  );

  // ==========================================================================
  // input select with deferred analog routing
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      input_select_q     <= `ADCSL_IS_RESET;
      channel_select_q   <= 4'h0;
      reference_select_q <= 1'b0;
      temp_sensor_en_q   <= 1'b0;
    end else begin
      if (wr_isel_t)
        input_select_q <= avs_writedata[7:0] & `ADCSL_IS_WMASK; // [RULE_09] [RULE_10]
      // routing frozen while converting [RULE_11]
      if (!converting_q || conv_end) begin
        channel_select_q   <= input_select_q[3:0];
        reference_select_q <= input_select_q[`ADCSL_IS_REF]; // 0 internal, 1 supply [RULE_12]
        temp_sensor_en_q   <= input_select_q[3:0] == `ADCSL_TEMP_CHANNEL; // [RULE_07]
      end
    end
  end

  // ==========================================================================
  // interrupts: sticky status cleared by read, mask, level output
  // a read clears only the bits its data carried, so an event that lands while
  // the read is in flight stays pending for the next read
  assign ev_set[`ADCSL_EV_DONE]       = conv_end;
  assign ev_set[`ADCSL_EV_SLEEP_CONV] = sleep_start;
  genvar ev;
  generate
    for (ev = 0; ev < 2; ev = ev + 1) begin : g_stat
      // the hardware set wins over a clear in the same cycle
      assign irq_stat_d[ev] = ev_set[ev] |
                              (irq_stat_q[ev] & ~(rd_stat_t & avs_readdata[ev]));
    end
  endgenerate
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      irq_q      <= 1'b0;
      done_irq_q <= 1'b0;
      wake_req_q <= 1'b0;
    end else begin
      if (wr_mask_t)
        irq_mask_q <= avs_writedata[1:0];
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_q & irq_mask_q);
      done_irq_q <= conversion_done_q && done_interrupt_enable_q; // [RULE_02]
      wake_req_q <= conversion_done_q && done_interrupt_enable_q; // [RULE_16]
    end
  end
endmodule // adcsl_top
`default_nettype wire

//--- tb/adcsl_cpu_model.sv
// behavioural core and sleep controller beside the converter control
`timescale 1ns/10ps
`default_nettype none
module adcsl_cpu_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // bench commands
  input  wire logic       go,
  input  wire logic [1:0] sleep_cmd,
  input  wire logic       early_wake,
  // converter control side
  input  wire logic       wake_req_q,
  input  wire logic       done_irq_q,
  output var  logic [1:0] sleep_state,
  output var  logic       cpu_halted,
  output var  logic       irq_ack
);
  logic prev_q;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_state <= 2'h0;
      cpu_halted <= 1'b0;
      irq_ack <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= done_irq_q;
      // vector taken once per request, asleep or awake
      irq_ack <= done_irq_q && !prev_q;
      if (wake_req_q || early_wake) begin
        sleep_state <= 2'h0;
        cpu_halted <= 1'b0;
      end else if (go)
        sleep_state <= sleep_cmd;
      else if (sleep_state != 2'h0) // clock halts a cycle after the command
        cpu_halted <= 1'b1;
    end
  end
endmodule // adcsl_cpu_model
`default_nettype wire

//--- tb/adcsl_top_assertions.sv
// port checker of the converter control
`timescale 1ns/10ps
`default_nettype none
module adcsl_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // sleep and analog side
  input wire logic        irq_ack,
  input wire logic        wake_req_q,
  input wire logic        done_irq_q,
  input wire logic [3:0]  channel_select_q,
  input wire logic        reference_select_q,
  input wire logic        temp_sensor_en_q,
  input wire logic        converting_q
);
  logic [12:0] cnt_q;
  // ==========
  // busy length in system clocks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      cnt_q <= 13'h0;
    else if (converting_q)
      cnt_q <= cnt_q + 13'h1;
    else
      cnt_q <= 13'h0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_ANSWER: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not on second edge");
  AST_ONE_LOW: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_RSVD: assert property (
    avs_read && !avs_waitrequest && avs_address == 8'h7c
    |-> {avs_readdata[31:7], avs_readdata[4]} == 26'h0) else $error("reserved bits set");
  AST_TEMP_ON: assert property (channel_select_q == 4'h8 |-> temp_sensor_en_q)
    else $error("sensor not enabled");
  AST_TEMP_OFF: assert property (
    temp_sensor_en_q |-> channel_select_q == 4'h8)
    else $error("sensor on for other channel");
  AST_WAKE: assert property (wake_req_q == done_irq_q)
    else $error("wake and done request differ");
  AST_REF_HOLD: assert property (
    converting_q && $past(converting_q) |-> $stable(reference_select_q))
    else $error("reference moved in conversion");
  AST_CH_HOLD: assert property (
    converting_q && $past(converting_q) |-> $stable(channel_select_q))
    else $error("channel moved in conversion");
  AST_TIME: assert property (
    $fell(converting_q) |-> cnt_q == 13'h680 || cnt_q == 13'hc80)
    else $error("conversion length off");
  AST_ACK: assert property (irq_ack && !converting_q |-> ##2 !done_irq_q)
    else $error("done request kept after ack");
endmodule // adcsl_chk
bind adcsl_top adcsl_chk u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack),
  .wake_req_q(wake_req_q), .done_irq_q(done_irq_q), .channel_select_q(channel_select_q),
  .reference_select_q(reference_select_q), .temp_sensor_en_q(temp_sensor_en_q),
  .converting_q(converting_q));
`default_nettype wire

//--- tb/adcsl_top_bench.sv
// self-checking bench of the converter control
`timescale 1ns/10ps
`default_nettype none
module adcsl_top_bench;
  logic sys_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic go = 1'b0, early_wake = 1'b0;
  logic avs_waitrequest, wake_req_q, done_irq_q, irq_q, cpu_halted, irq_ack;
  logic reference_select_q, temp_sensor_en_q, converting_q;
  logic [7:0] avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, seed = 32'h00012e51;
  logic [1:0] sleep_state, sleep_cmd = 2'h0;
  logic [9:0] analog_code = 10'h0;
  logic [3:0] channel_select_q;
  int errors = 0, num_checks = 0, acks = 0, n, a, isel_m;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (irq_ack === 1'b1) acks <= acks + 1;
  adcsl_top dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_state(sleep_state), .cpu_halted(cpu_halted), .irq_ack(irq_ack),
    .wake_req_q(wake_req_q), .done_irq_q(done_irq_q), .irq_q(irq_q),
    .analog_code(analog_code), .channel_select_q(channel_select_q),
    .reference_select_q(reference_select_q), .temp_sensor_en_q(temp_sensor_en_q),
    .converting_q(converting_q));
  adcsl_cpu_model u_cpu (.sys_clk(sys_clk), .resetn(resetn), .go(go), .sleep_cmd(sleep_cmd),
    .early_wake(early_wake), .wake_req_q(wake_req_q), .done_irq_q(done_irq_q),
    .sleep_state(sleep_state), .cpu_halted(cpu_halted), .irq_ack(irq_ack));
  // ==========
  // shared tasks
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) begin errors++; tally_and_finish; end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // bounded wait for busy level, n returns the cycles spent
  task wait_conv(input logic lvl);
    n = 0;
    while (converting_q !== lvl && n < 4000) begin @(posedge sys_clk); n++; end
    if (n >= 4000) begin errors++; tally_and_finish; end
  endtask
  task sleep(input logic [1:0] s);
    @(posedge sys_clk);
    sleep_cmd <= s;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  function logic [9:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed[9:0];
  endfunction
  function logic [15:0] view(input logic [9:0] c, input logic l);
    view = l ? {c, 6'h0} : {6'h0, c};
  endfunction
  // reference toggled mid-conversion, then both result layouts
  task conv(input int first);
    logic [9:0] c;
    c = rnd();
    analog_code <= c;
    bus(1'b1, 8'h7a, 32'hc0);
    wait_conv(1'b1);
    isel_m ^= 32'h40;
    bus(1'b1, 8'h7c, isel_m);
    chk("ref held", reference_select_q, !isel_m[6]);
    wait_conv(1'b0);
    chk("conv time", n > (first ? 3072 : 1536) && n <= (first ? 3200 : 1664), 1);
    @(posedge sys_clk);
    chk("ref updated", reference_select_q, isel_m[6]);
    bus(1'b0, 8'h7a, 32'h0);
    chk("ctrl done", q & 32'hd0, 32'h90);
    repeat (2) begin
      bus(1'b0, 8'h78, 32'h0);
      chk("res low", q, view(c, isel_m[5]) & 16'hff);
      bus(1'b0, 8'h79, 32'h0);
      chk("res high", q, view(c, isel_m[5]) >> 8);
      isel_m ^= 32'h20;
      bus(1'b1, 8'h7c, isel_m);
    end
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    bus(1'b0, 8'h7c, 32'h0);
    chk("isel reset", q, 32'h0);
    bus(1'b0, 8'h7a, 32'h0);
    chk("ctrl reset", q, 32'h0);
    bus(1'b1, 8'h7c, 32'hff);
    bus(1'b0, 8'h7c, 32'h0);
    chk("isel rsvd", q, 32'h6f);
    chk("ref supply", reference_select_q, 1);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 8'h7c, i);
      repeat (2) @(posedge sys_clk);
      chk("channel", channel_select_q, i);
      chk("sensor", temp_sensor_en_q, i == 8);
    end
    isel_m = 8;
    bus(1'b1, 8'h7c, isel_m);
    bus(1'b1, 8'h90, 32'hff);
    bus(1'b0, 8'h90, 32'h0);
    chk("unmapped", q, 32'h0);
    conv(1);
    conv(0);
    bus(1'b1, 8'h84, 32'h3);
    bus(1'b1, 8'h7a, 32'h98);
    bus(1'b0, 8'h80, 32'h0);
    a = acks;
    sleep(2'h2);
    wait_conv(1'b1);
    chk("sleep start", cpu_halted, 1);
    wait_conv(1'b0);
    repeat (4) @(posedge sys_clk);
    chk("woken", sleep_state, 0);
    chk("handler", acks, a + 1);
    chk("irq on", irq_q, 1);
    bus(1'b0, 8'h80, 32'h0);
    chk("status", q, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk("irq clear", irq_q, 0);
    bus(1'b1, 8'h84, 32'h0);
    sleep(2'h1);
    wait_conv(1'b1);
    early_wake <= 1'b1;
    @(posedge sys_clk);
    early_wake <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("early awake", {sleep_state, converting_q}, 3'h1);
    wait_conv(1'b0);
    repeat (4) @(posedge sys_clk);
    chk("late request", acks, a + 2);
    chk("irq masked", irq_q, 0);
    bus(1'b0, 8'h80, 32'h0);
    sleep(2'h3);
    repeat (300) @(posedge sys_clk);
    chk("no pd start", converting_q, 0);
    bus(1'b0, 8'h7a, 32'h0);
    chk("enable kept", q[7], 1);
    tally_and_finish;
  end
  initial begin
    #1000000;
    errors++;
    tally_and_finish;
  end
endmodule // adcsl_top_bench
`default_nettype wire
